// file: rtl/gmi_cfg.svh
// constants for the input monitor and interrupt controller
`ifndef GMI_CFG_SVH
`define GMI_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define GMI_OFS_MONITOR 8'h2F
`define GMI_OFS_CONFIG 8'h32
`define GMI_OFS_MASK 8'h33
`define GMI_OFS_LATCH 8'h36

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define GMI_RST_MONITOR 8'h00
`define GMI_RST_CONFIG 8'h00
`define GMI_RST_MASK 8'hFF
`define GMI_RST_LATCH 8'h00
`define GMI_CFG_WMASK 8'hE4
`define GMI_POL_BIT 7
`define GMI_MODE_HI 6
`define GMI_MODE_LO 5
`define GMI_SEL_BIT 2
`define GMI_SRC_CLKERR 7
`define GMI_SRC_PLL 6
`define GMI_MON_PIN_ONE 7
`define GMI_MON_PIN_FOUR 4
`define GMI_FUNC_INPUT 3'h1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GMI_PULSE_NS 2000000
`define GMI_CLK_NS 50

`endif

// file: rtl/gmi_pkg.sv
// types for the input monitor and interrupt controller
package gmi_pkg;

  typedef enum logic [1:0]
  {
    GMI_MODE_LEVEL = 2'h0,
    GMI_MODE_RSVD = 2'h1,
    GMI_MODE_PERIODIC = 2'h2,
    GMI_MODE_ONESHOT = 2'h3
  } gmi_mode_t;

  typedef enum logic [1:0]
  {
    GMI_ST_IDLE = 2'h0,
    GMI_ST_ON = 2'h1,
    GMI_ST_OFF = 2'h3
  } gmi_state_t;

endpackage

// file: rtl/gmi_pulse_gen.sv
// interrupt request shaper: level, periodic and one-shot modes
`timescale 1ns/100ps
`include "gmi_cfg.svh"

module gmi_pulse_gen #(
  parameter int unsigned PULSE_CYCLES = `GMI_PULSE_NS / `GMI_CLK_NS
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire gmi_pkg::gmi_mode_t mode,
  input wire logic pending,
  input wire logic fresh_evt,
  output logic req
);
  import gmi_pkg::*;

  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

  gmi_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic last;
  logic retrig;

  assign last = (cnt_q == CW'(PULSE_CYCLES - 1));
  assign retrig = (mode == GMI_MODE_ONESHOT) && fresh_evt;

  // ------------------------------------------------------------
  // phase state
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= GMI_ST_IDLE;
    else
    begin
      unique case (state_q)
        GMI_ST_IDLE:
        begin
          if ((mode == GMI_MODE_PERIODIC && pending) || retrig)
            state_q <= GMI_ST_ON;
        end
        GMI_ST_ON:
        begin
          if (mode == GMI_MODE_PERIODIC)
          begin
            if (!pending)
              state_q <= GMI_ST_IDLE;
            else if (last)
              state_q <= GMI_ST_OFF;
          end
          else if (mode == GMI_MODE_ONESHOT)
          begin
            if (last && !retrig)
              state_q <= GMI_ST_IDLE;
          end
          else
            state_q <= GMI_ST_IDLE;
        end
        GMI_ST_OFF:
        begin
          if (mode != GMI_MODE_PERIODIC || !pending)
            state_q <= GMI_ST_IDLE;
          else if (last)
            state_q <= GMI_ST_ON;
        end
        default:
          state_q <= GMI_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // phase timer
  // ------------------------------------------------------------
  // a new event in one-shot mode restarts the pulse rather than queueing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (state_q == GMI_ST_IDLE || last || retrig)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CW'(1);
  end

  // reserved mode never starts a pulse; an on phase it interrupts ends after one cycle
  assign req = (mode == GMI_MODE_LEVEL) ? pending : (state_q == GMI_ST_ON);

endmodule

// file: rtl/gmi_top.sv
// general input monitor and interrupt latch, mask and output logic
`timescale 1ns/100ps
`include "gmi_cfg.svh"

module gmi_top #(
  parameter int unsigned PULSE_CYCLES = `GMI_PULSE_NS / `GMI_CLK_NS
)(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic GENERAL_INPUT_ONE,
  input wire logic GENERAL_INPUT_TWO,
  input wire logic GENERAL_INPUT_THREE,
  input wire logic GENERAL_INPUT_FOUR,
  input wire logic [2:0] PIN_ONE_FUNCTION,
  input wire logic [2:0] PIN_TWO_FUNCTION,
  input wire logic [2:0] PIN_THREE_FUNCTION,
  input wire logic [2:0] PIN_FOUR_FUNCTION,
  input wire logic CLK_ERR_EVENT,
  input wire logic PLL_LOCK_EVENT,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  output logic IRQ_PIN
);
  import gmi_pkg::*;

  function automatic logic is_input(input logic [2:0] func);
    is_input = (func == `GMI_FUNC_INPUT);
  endfunction

  logic rst_meta_n_q;
  logic rst_n_q;
  logic [7:0] monitor_q;
  logic [7:0] config_q;
  logic [7:0] mask_q;
  logic [7:0] latch_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic [7:0] events;
  logic [7:0] latch_view;
  logic latch_rd;
  logic pending;
  logic fresh_evt;
  logic req;
  gmi_mode_t mode;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_meta_n_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_n_q <= 1'b1;
      rst_n_q <= rst_meta_n_q;
    end
  end

  // ------------------------------------------------------------
  // input monitor
  // ------------------------------------------------------------
  // pins in another function read as zero so stale levels never show
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      monitor_q <= `GMI_RST_MONITOR;
    else
      monitor_q <= {GENERAL_INPUT_ONE & is_input(PIN_ONE_FUNCTION),
                    GENERAL_INPUT_TWO & is_input(PIN_TWO_FUNCTION),
                    GENERAL_INPUT_THREE & is_input(PIN_THREE_FUNCTION),
                    GENERAL_INPUT_FOUR & is_input(PIN_FOUR_FUNCTION),
                    4'h0};
  end

  // ------------------------------------------------------------
  // configuration and mask
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      config_q <= `GMI_RST_CONFIG;
    else if (REG_WRITE && REG_ADDR == `GMI_OFS_CONFIG)
      config_q <= REG_WDATA & `GMI_CFG_WMASK;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mask_q <= `GMI_RST_MASK;
    else if (REG_WRITE && REG_ADDR == `GMI_OFS_MASK)
      mask_q <= REG_WDATA;
  end

  assign mode = gmi_mode_t'(config_q[`GMI_MODE_HI:`GMI_MODE_LO]);

  // ------------------------------------------------------------
  // event latch
  // ------------------------------------------------------------
  assign events = {CLK_ERR_EVENT, PLL_LOCK_EVENT, 6'h00};
  assign latch_view = config_q[`GMI_SEL_BIT] ? (latch_q & ~mask_q) : latch_q;
  assign latch_rd = REG_READ && (REG_ADDR == `GMI_OFS_LATCH);

  // only the bits the host was shown are cleared; a same-cycle event survives
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      latch_q <= `GMI_RST_LATCH;
    else
      latch_q <= (latch_rd ? (latch_q & ~latch_view) : latch_q) | events;
  end

  assign pending = |(latch_q & ~mask_q);
  assign fresh_evt = |(events & ~mask_q);

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 8'h00;
    else if (REG_READ)
    begin
      unique case (REG_ADDR)
        `GMI_OFS_MONITOR: rdata_q <= monitor_q;
        `GMI_OFS_CONFIG: rdata_q <= config_q;
        `GMI_OFS_MASK: rdata_q <= mask_q;
        `GMI_OFS_LATCH: rdata_q <= latch_view;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA = rdata_q;

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  gmi_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) gmi_pulse_gen_i (
    .clk(REF_CLK),
    .rst_n(rst_n_q),
    .mode(mode),
    .pending(pending),
    .fresh_evt(fresh_evt),
    .req(req)
  );

  // reset value is the idle level for the reset polarity (active low)
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_q <= 1'b1;
    else
      irq_q <= req ~^ config_q[`GMI_POL_BIT];
  end

  assign IRQ_PIN = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_q);

  logic irq_active;
  logic seen_q;
  logic [31:0] run_q;

  assign irq_active = (irq_q == config_q[`GMI_POL_BIT]);

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      run_q <= 32'h0;
    else if (irq_active && mode == GMI_MODE_PERIODIC)
      run_q <= run_q + 32'h1;
    else
      run_q <= 32'h0;
  end

  // first edge after release leaves the monitor at its reset value
  mon_pin_a: assert property (seen_q && is_input(PIN_ONE_FUNCTION) |=>
    monitor_q[`GMI_MON_PIN_ONE] == $past(GENERAL_INPUT_ONE))
    else $error("pin one level not mirrored");
  mon_off_a: assert property (!is_input(PIN_FOUR_FUNCTION) |=>
    !monitor_q[`GMI_MON_PIN_FOUR])
    else $error("pin four shown while not an input");
  // pin lags a polarity write by one flop, so config must hold steady
  irq_idle_a: assert property ((mode == GMI_MODE_LEVEL && !pending &&
    $stable(config_q))[*3] |-> irq_q == !config_q[`GMI_POL_BIT])
    else $error("interrupt pin not at idle level");
  level_mode_a: assert property ((mode == GMI_MODE_LEVEL && pending)[*2] |->
    irq_active)
    else $error("level mode interrupt not asserted");
  periodic_len_a: assert property (run_q <= PULSE_CYCLES)
    else $error("periodic pulse too long");
  oneshot_go_a: assert property (mode == GMI_MODE_ONESHOT && fresh_evt &&
    $stable(config_q) |-> ##[1:2] irq_active)
    else $error("one-shot pulse missing");
  readback_sel_a: assert property (latch_rd && config_q[`GMI_SEL_BIT] |=>
    REG_RDATA == $past(latch_q & ~mask_q))
    else $error("masked latch bit read back");
  masked_quiet_a: assert property ((mode == GMI_MODE_LEVEL &&
    (latch_q & ~mask_q) == 8'h00 && $stable(config_q))[*3] |-> !irq_active)
    else $error("masked source raised interrupt");
  mask_reset_a: assert property (!seen_q |-> mask_q == `GMI_RST_MASK)
    else $error("mask not all ones after reset");
  clkerr_set_a: assert property (CLK_ERR_EVENT |=> latch_q[`GMI_SRC_CLKERR])
    else $error("clock error not latched");
  pll_set_a: assert property (PLL_LOCK_EVENT |=> latch_q[`GMI_SRC_PLL])
    else $error("pll lock not latched");
  read_clear_a: assert property (latch_rd && !CLK_ERR_EVENT && !PLL_LOCK_EVENT |=>
    (latch_q & $past(latch_view)) == 8'h00)
    else $error("latch not cleared by read");

  level_irq_c: cover property (mode == GMI_MODE_LEVEL && irq_active);
  periodic_irq_c: cover property (mode == GMI_MODE_PERIODIC && $fell(irq_active) && pending);
  oneshot_irq_c: cover property (mode == GMI_MODE_ONESHOT && $rose(irq_active));
  read_clear_c: cover property (latch_rd && latch_view != 8'h00);

endmodule

// file: test/gmi_host_model.sv
// host model: register strobes and read data capture
`timescale 1ns/100ps
module gmi_host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // released lines carry the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  // sampled one cycle late: read data holds until the next read
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// file: test/gmi_top_bench.sv
// self-checking bench for the input monitor and interrupt controller
`timescale 1ns/100ps
module gmi_top_bench;
  localparam int P = 8;
  typedef struct {logic [3:0] pins; logic [11:0] funcs; logic [7:0] exp;} gmi_row_t;
  gmi_row_t rows [5];
  logic clk, rstn, clk_err, pll_lock, wr, rd, irq;
  logic [3:0] pins;
  logic [11:0] funcs;
  logic [7:0] addr, wdata, rdata, d;
  int err_count, num_checks, n;

  gmi_top #(.PULSE_CYCLES(P)) gmi_top_i (
    .REF_CLK(clk), .RSTN(rstn),
    .GENERAL_INPUT_ONE(pins[3]), .GENERAL_INPUT_TWO(pins[2]),
    .GENERAL_INPUT_THREE(pins[1]), .GENERAL_INPUT_FOUR(pins[0]),
    .PIN_ONE_FUNCTION(funcs[11:9]), .PIN_TWO_FUNCTION(funcs[8:6]),
    .PIN_THREE_FUNCTION(funcs[5:3]), .PIN_FOUR_FUNCTION(funcs[2:0]),
    .CLK_ERR_EVENT(clk_err), .PLL_LOCK_EVENT(pll_lock),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ(rd),
    .REG_RDATA(rdata), .IRQ_PIN(irq)
  );

  gmi_host_model gmi_host_model_i (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    gmi_host_model_i.read_reg(a, d);
    check8(d, e);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    gmi_host_model_i.write_reg(a, v);
  endtask

  // one-cycle event pulse: 1 clock error, 0 pll lock
  task automatic fire(input logic which);
    @(negedge clk);
    clk_err = which;
    pll_lock = ~which;
    @(negedge clk);
    clk_err = 1'b0;
    pll_lock = 1'b0;
  endtask

  task automatic pin_after(input int k, input logic e);
    repeat (k) @(negedge clk);
    check8({7'h00, irq}, {7'h00, e});
  endtask

  // bounded: a stuck pin stops at 4*P and fails the count compare
  task automatic run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (irq === lvl && cnt < 4 * P)
    begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(100000 * 50);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rstn = 1'b0;
    pins = 4'h0;
    funcs = 12'h000;
    clk_err = 1'b0;
    pll_lock = 1'b0;
    err_count = 0;
    num_checks = 0;
    rows[0] = '{4'hA, 12'h249, 8'hA0};
    rows[1] = '{4'hF, 12'h000, 8'h00};
    rows[2] = '{4'hF, 12'h28F, 8'hA0};
    rows[3] = '{4'h5, 12'h249, 8'h50};
    rows[4] = '{4'hF, 12'h72E, 8'h00};
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    pin_after(0, 1'b1);
    rc(8'h2F, 8'h00);
    rc(8'h32, 8'h00);
    rc(8'h33, 8'hFF);
    rc(8'h36, 8'h00);
    rc(8'h40, 8'h00);
    foreach (rows[i])
    begin
      pins = rows[i].pins;
      funcs = rows[i].funcs;
      rc(8'h2F, rows[i].exp);
    end
    wreg(8'h32, 8'hFF);
    rc(8'h32, 8'hE4);
    wreg(8'h36, 8'hFF);
    rc(8'h36, 8'h00);
    // level mode, clock error unmasked
    wreg(8'h32, 8'h00);
    wreg(8'h33, 8'h7F);
    fire(1'b1);
    pin_after(2, 1'b0);
    rc(8'h36, 8'h80);
    pin_after(2, 1'b1);
    rc(8'h36, 8'h00);
    // masked pll source, hidden then shown by readback select
    wreg(8'h32, 8'h04);
    fire(1'b0);
    pin_after(2, 1'b1);
    rc(8'h36, 8'h00);
    wreg(8'h32, 8'h00);
    rc(8'h36, 8'h40);
    // new event in the same cycle as the clearing read survives
    fire(1'b1);
    fork
      rc(8'h36, 8'h80);
      fire(1'b0);
    join
    rc(8'h36, 8'h40);
    // active high polarity
    wreg(8'h32, 8'h80);
    pin_after(2, 1'b0);
    fire(1'b1);
    pin_after(2, 1'b1);
    rc(8'h36, 8'h80);
    // reserved mode never asserts
    wreg(8'h32, 8'h20);
    fire(1'b1);
    pin_after(3, 1'b1);
    rc(8'h36, 8'h80);
    // one-shot mode
    wreg(8'h33, 8'h3F);
    wreg(8'h32, 8'h60);
    fire(1'b0);
    pin_after(1, 1'b0);
    run_len(1'b0, n);
    check8(8'(n), 8'(P));
    pin_after(P, 1'b1);
    rc(8'h36, 8'h40);
    // periodic mode
    wreg(8'h32, 8'h40);
    fire(1'b1);
    repeat (2) @(negedge clk);
    run_len(1'b0, n);
    check8(8'(n), 8'(P));
    run_len(1'b1, n);
    check8(8'(n), 8'(P));
    pin_after(0, 1'b0);
    rc(8'h36, 8'h80);
    pin_after(2, 1'b1);
    // reset in mid-run restores the mask
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    rc(8'h33, 8'hFF);
    rc(8'h32, 8'h00);
    wrap_up();
  end
endmodule
